// >>> logic/vfc_checker.sv
// frame crc checker: register port, stream pass-through, per-component crc
// Notes on behaviour
// [RL1] control bits 2:0 pick 1, 2 or 4 pixels per clock; resets to 001.
// [RL2] writing one to control bit 4 clears all stored checksum results; a frame-start capture in the clearing cycle wins instead.
// [RL3] control bit 31 set means ycbcr 4:2:2 stream, else rgb.
// [RL4] first checksum in bits 15:0, second in 31:16 of one read-only word.
// [RL5] third checksum in bits 15:0 of another read-only word.
// [RL6] geometry word: active width in 15:0, active height in 31:16.
// [RL7] missing-component counts in 4-bit fields 3:0, 7:4 and 11:8.
// [RL8] register-port reset returns every register to its default.
// [RL9] video reset clears the whole checksum datapath.
// [RL10] software programs geometry, mode and format before sending video.
// [RL11] each vertical sync loads both result words from the accumulators.
// [RL12] one checksum unit per component per pixel lane.
// [RL13] each unit computes crc16 with polynomial x16+x15+x2+1.
// [RL14] each lane-0 unit is seeded with the checksum of the previous beat, each later lane with the lane below.
// [RL15] 4:2:2 single-pixel: chroma field goes to cb then cr, alternating.
// [RL16] 4:2:2 single-pixel: cb and cr inputs hold steady for two cycles.
// [RL17] single-pixel mode: each lane-0 unit takes its component every cycle, the cb and cr units every other cycle in 4:2:2.
// [RL18] two-pixel mode: two inputs per component loaded each beat, one each for cb and cr in 4:2:2.
// [RL19] earliest pixel of a beat sits in the lowest data bits.
// [RL20] 4:2:2 pixels carry chroma in the upper part, luma in the lower.
// [RL21] incoming stream passes unchanged to the output stream.
// [RL22] lanes chain in pixel order; four-pixel mode chains four units.
// [RL23] accumulators restart from the initial seed after each capture.
module vfc_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic vid_reset_n,
  input wire logic [vfc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [vfc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [vfc_pkg::DATA_W-1:0] s_axis_video_tdata,
  input wire logic s_axis_video_tuser,
  input wire logic s_axis_video_tlast,
  input wire logic s_axis_video_tvalid,
  output logic s_axis_video_tready,
  output logic [vfc_pkg::DATA_W-1:0] m_axis_video_tdata,
  output logic m_axis_video_tuser,
  output logic m_axis_video_tlast,
  output logic m_axis_video_tvalid,
  input wire logic m_axis_video_tready
);
  localparam int B = vfc_pkg::BPC;
  localparam int PW = vfc_pkg::PIX_W;

  logic [2:0] mode_r;
  logic ycc_r;
  logic clear_r;
  logic [15:0] active_width_r;
  logic [15:0] active_height_r;
  logic [2:0][15:0] res_r;
  logic [2:0][vfc_pkg::MISS_W-1:0] miss_r;
  logic [2:0][15:0] acc_r;
  logic phase_r;
  logic [15:0] pix_cnt_r;
  logic line_short_r;
  logic aw_hs_r;
  logic ar_hs_r;

  // ----------------------------------------------------------------
  // stream pass-through through the fifo
  // ----------------------------------------------------------------
  vfc_pkg::vfc_beat_t beat_in;
  vfc_pkg::vfc_beat_t beat_out;
  assign beat_in = '{data: s_axis_video_tdata, sof: s_axis_video_tuser,
                     eol: s_axis_video_tlast};

  vfc_fifo #(
    .WIDTH(vfc_pkg::BEAT_W),
    .DEPTH(vfc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(vid_reset_n),
    .in_data(beat_in),
    .in_valid(s_axis_video_tvalid),
    .in_ready(s_axis_video_tready),
    .out_data(beat_out),
    .out_valid(m_axis_video_tvalid),
    .out_ready(m_axis_video_tready)
  ); // see [RL21]

  assign m_axis_video_tdata = beat_out.data;
  assign m_axis_video_tuser = beat_out.sof;
  assign m_axis_video_tlast = beat_out.eol;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire beat_take = s_axis_video_tvalid && s_axis_video_tready;
  wire cap_pulse = beat_take && s_axis_video_tuser;
  // a non one-hot mode falls back to one pixel rather than stalling the sums
  wire [2:0] ppc_n = (mode_r == vfc_pkg::MODE_4PPC) ? 3'h4 :
                     (mode_r == vfc_pkg::MODE_2PPC) ? 3'h2 : 3'h1; // see [RL1]
  wire [2:0][15:0] acc_nxt;
  wire [2:0][4:0][15:0] chain;
  // pixel parity restarts on the frame-start beat itself, not one beat later
  wire phase_now = cap_pulse ? 1'b0 : phase_r;

  // ----------------------------------------------------------------
  // checksum lanes: comp 0 = r/cr, 1 = g/cb, 2 = b/y
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 3; c++) begin : g_comp
    // frame start discards the old sum and begins from the seed
    assign chain[c][0] = cap_pulse ? vfc_pkg::CRC_SEED : acc_r[c]; // see [RL23] [RL14]
    for (genvar l = 0; l < vfc_pkg::PPC_MAX; l++) begin : g_lane
      wire [PW-1:0] pix = s_axis_video_tdata[l*PW +: PW]; // see [RL19]
      wire [B-1:0] rgb_din = (c == 0) ? pix[3*B-1:2*B] :
                             (c == 1) ? pix[B-1:0] : pix[2*B-1:B];
      wire [B-1:0] ycc_din = (c == 2) ? pix[B-1:0] : pix[2*B-1:B]; // see [RL20]
      wire [B-1:0] din = ycc_r ? ycc_din : rgb_din; // see [RL3]
      // odd absolute pixels carry cr, even ones cb
      wire parity = 1'(l % 2) ^ phase_now;
      wire chroma_ok = !ycc_r || (c == 2) || (parity == (c == 0)); // see [RL15] [RL16]
      wire lane_on = (3'(l) < ppc_n) && chroma_ok; // see [RL17] [RL18]
      wire [15:0] dout;
      vfc_crc_unit #(
        .DIN_W(B)
      ) u_crc (
        .seed(chain[c][l]),
        .din(din),
        .dout(dout)
      ); // see [RL12]
      // an idle lane hands its seed on so the chain stays in pixel order
      assign chain[c][l+1] = lane_on ? dout : chain[c][l]; // see [RL22]
    end
    assign acc_nxt[c] = chain[c][vfc_pkg::PPC_MAX];
  end

  // ----------------------------------------------------------------
  // video-side datapath state
  // ----------------------------------------------------------------
  wire [15:0] line_len = pix_cnt_r + 16'(ppc_n);

  always_ff @(posedge core_clk or negedge vid_reset_n) begin
    if (!vid_reset_n) begin
      acc_r <= '0; // see [RL9]
      phase_r <= 1'b0;
      pix_cnt_r <= '0;
      line_short_r <= 1'b0;
    end else begin
      line_short_r <= beat_take && s_axis_video_tlast && (line_len < active_width_r);
      if (beat_take) begin
        acc_r <= acc_nxt; // see [RL14]
        phase_r <= (cap_pulse ? 1'b0 : phase_r) ^ ppc_n[0]; // see [RL15]
        pix_cnt_r <= s_axis_video_tlast ? 16'h0000 : line_len;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port handshake
  // ----------------------------------------------------------------
  wire wr_fire = s_axi_awvalid && s_axi_wvalid && !aw_hs_r && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && !ar_hs_r && !s_axi_rvalid;
  wire wr_fmt = aw_hs_r && (s_axi_awaddr == vfc_pkg::OFS_FORMAT);
  wire wr_geo = aw_hs_r && (s_axi_awaddr == vfc_pkg::OFS_GEOMETRY);
  wire wr_ro = (s_axi_awaddr == vfc_pkg::OFS_CRC_RG) || (s_axi_awaddr == vfc_pkg::OFS_CRC_B)
               || (s_axi_awaddr == vfc_pkg::OFS_MISSING);
  wire wr_hit = (s_axi_awaddr == vfc_pkg::OFS_FORMAT) || (s_axi_awaddr == vfc_pkg::OFS_GEOMETRY)
                || wr_ro;
  wire [31:0] fmt_word = {ycc_r, 28'h0000000, mode_r};
  wire [31:0] geo_word = {active_height_r, active_width_r};
  wire [31:0] geo_new;
  for (genvar k = 0; k < 4; k++) begin : g_strb
    assign geo_new[k*8 +: 8] = s_axi_wstrb[k] ? s_axi_wdata[k*8 +: 8] : geo_word[k*8 +: 8];
  end
  wire rd_hit = (s_axi_araddr == vfc_pkg::OFS_FORMAT) || (s_axi_araddr == vfc_pkg::OFS_GEOMETRY)
                || (s_axi_araddr == vfc_pkg::OFS_CRC_RG) || (s_axi_araddr == vfc_pkg::OFS_CRC_B)
                || (s_axi_araddr == vfc_pkg::OFS_MISSING);
  wire [31:0] rd_word =
    (s_axi_araddr == vfc_pkg::OFS_FORMAT) ? fmt_word :
    (s_axi_araddr == vfc_pkg::OFS_CRC_RG) ? {res_r[1], res_r[0]} : // see [RL4]
    (s_axi_araddr == vfc_pkg::OFS_CRC_B) ? {16'h0000, res_r[2]} : // see [RL5]
    (s_axi_araddr == vfc_pkg::OFS_GEOMETRY) ? geo_word : // see [RL6]
    (s_axi_araddr == vfc_pkg::OFS_MISSING) ? {20'h00000, miss_r[2], miss_r[1], miss_r[0]} :
    32'h00000000; // see [RL7]

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hs_r <= 1'b0;
      ar_hs_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= vfc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= vfc_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      aw_hs_r <= wr_fire;
      ar_hs_r <= rd_fire;
      if (aw_hs_r) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? vfc_pkg::RESP_OKAY : vfc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (ar_hs_r) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? vfc_pkg::RESP_OKAY : vfc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_awready = aw_hs_r;
  assign s_axi_wready = aw_hs_r;
  assign s_axi_arready = ar_hs_r;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= vfc_pkg::MODE_RESET; // see [RL8] [RL1]
      ycc_r <= 1'b0;
      clear_r <= 1'b0;
      active_width_r <= vfc_pkg::GEOM_RESET;
      active_height_r <= vfc_pkg::GEOM_RESET;
      res_r <= '0;
      miss_r <= '0;
    end else begin
      clear_r <= wr_fmt && s_axi_wstrb[0] && s_axi_wdata[vfc_pkg::FMT_CLEAR_BIT]; // see [RL2]
      if (wr_fmt && s_axi_wstrb[0]) mode_r <= s_axi_wdata[2:0]; // see [RL1]
      if (wr_fmt && s_axi_wstrb[3]) ycc_r <= s_axi_wdata[vfc_pkg::FMT_YCC_BIT]; // see [RL3]
      if (wr_geo) begin
        active_width_r <= geo_new[15:0]; // see [RL6]
        active_height_r <= geo_new[31:16];
      end
      // a capture in the clearing cycle wins so a frame is never lost
      if (cap_pulse) res_r <= acc_r; // see [RL11]
      else if (clear_r) res_r <= '0; // see [RL2]
      for (int i = 0; i < 3; i++) begin
        if (line_short_r) begin
          if (miss_r[i] != '1) miss_r[i] <= miss_r[i] + 1'b1; // see [RL7]
        end else if (clear_r) miss_r[i] <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mode_reset: assert property (@(posedge core_clk) // see [RL8]
    $rose(reset_n) |-> mode_r == vfc_pkg::MODE_1PPC)
    else $error("mode not at default after reset");
  a_clear_results: assert property (@(posedge core_clk) disable iff (!reset_n) // see [RL2]
    clear_r && !cap_pulse |=> res_r == '0)
    else $error("results not cleared");
  a_vsync_capture: assert property (@(posedge core_clk) disable iff (!reset_n) // see [RL11]
    cap_pulse |=> res_r[2] == $past(acc_r[2]) && res_r[0] == $past(acc_r[0]))
    else $error("results not captured at frame start");
  a_ppc_decode: assert property (@(posedge core_clk) disable iff (!reset_n) // see [RL1]
    mode_r == vfc_pkg::MODE_2PPC |-> ppc_n == 3'h2)
    else $error("pixel mode decoded wrongly");
  a_chroma_alternate: assert property (@(posedge core_clk) disable iff (!vid_reset_n) // see [RL15]
    ycc_r && ppc_n == 3'h1 && beat_take && !cap_pulse |=> phase_r != $past(phase_r))
    else $error("chroma phase did not alternate");
  a_chroma_hold: assert property (@(posedge core_clk) disable iff (!vid_reset_n) // see [RL16]
    ycc_r && ppc_n == 3'h1 && beat_take && !phase_r |-> acc_nxt[0] == chain[0][0])
    else $error("cr unit moved on a cb sample");
  a_lane_idle: assert property (@(posedge core_clk) disable iff (!vid_reset_n) // see [RL22]
    ppc_n == 3'h1 |-> chain[2][4] == chain[2][1])
    else $error("unused lanes altered the sum");
  a_stream_hold: assert property (@(posedge core_clk) disable iff (!vid_reset_n) // see [RL21]
    m_axis_video_tvalid && !m_axis_video_tready |=> m_axis_video_tvalid
    && $stable(m_axis_video_tdata))
    else $error("output beat changed while stalled");
  a_miss_saturate: assert property (@(posedge core_clk) disable iff (!reset_n) // see [RL7]
    miss_r[0] == 4'hf && !clear_r |=> miss_r[0] == 4'hf)
    else $error("missing count wrapped");
  a_miss_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // see [RL2]
    clear_r && !line_short_r |=> miss_r == '0)
    else $error("missing counts not cleared");
  a_vid_reset: assert property (@(posedge core_clk) // see [RL9]
    $rose(vid_reset_n) |-> acc_r == '0 && !phase_r)
    else $error("checksum datapath not reset");
  a_lane_chain: assert property (@(posedge core_clk) disable iff (!vid_reset_n) // see [RL22]
    ppc_n == 3'h2 |-> chain[1][4] == chain[1][2])
    else $error("lanes beyond two altered the sum");
  a_format_write: assert property (@(posedge core_clk) disable iff (!reset_n) // see [RL3]
    wr_fmt && s_axi_wstrb[3] |=> ycc_r == $past(s_axi_wdata[vfc_pkg::FMT_YCC_BIT]))
    else $error("colour format not written");
  a_read_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // see [RL4]
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while stalled");
endmodule

// >>> logic/vfc_pkg.sv
// shared constants and types for the video frame crc checker
package vfc_pkg;
  // ----------------------------------------------------------------
  // stream geometry
  // ----------------------------------------------------------------
  localparam int BPC = 8;
  localparam int NCOMP = 3;
  localparam int PPC_MAX = 4;
  localparam int PIX_W = NCOMP * BPC;
  localparam int DATA_W = PPC_MAX * PIX_W;
  localparam int FIFO_DEPTH = 16;
  localparam int MISS_W = 4;
  localparam int AXI_AW = 8;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic sof;
    logic eol;
  } vfc_beat_t;

  localparam int BEAT_W = $bits(vfc_beat_t);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [AXI_AW-1:0] OFS_FORMAT = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_CRC_RG = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_CRC_B = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_GEOMETRY = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_MISSING = 8'h10;

  localparam int FMT_CLEAR_BIT = 4;
  localparam int FMT_YCC_BIT = 31;
  localparam logic [2:0] MODE_1PPC = 3'h1;
  localparam logic [2:0] MODE_2PPC = 3'h2;
  localparam logic [2:0] MODE_4PPC = 3'h4;
  localparam logic [2:0] MODE_RESET = 3'h1;
  localparam logic [15:0] GEOM_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // checksum and bus answers
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/vfc_crc_unit.sv
// one combinational crc16 step over one component sample
module vfc_crc_unit #(
  parameter int DIN_W = 8
) (
  input wire logic [15:0] seed,
  input wire logic [DIN_W-1:0] din,
  output logic [15:0] dout
);
  // ----------------------------------------------------------------
  // msb-first serial division unrolled over the sample
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] s, input logic [DIN_W-1:0] d);
    logic [15:0] c;
    logic fb;
    c = s;
    fb = 1'b0;
    for (int i = DIN_W - 1; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? vfc_pkg::CRC_POLY : 16'h0000); // see [RL13]
    end
    return c;
  endfunction

  assign dout = crc_step(seed, din);
endmodule

// >>> logic/vfc_fifo.sv
// small stream fifo with registered read data and registered ready
module vfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  wire push = in_valid && in_ready;
  wire pop = (count_r != '0) && (!out_valid || out_ready);

  // ----------------------------------------------------------------
  // occupancy; ready is registered so it can drive a port directly
  // ----------------------------------------------------------------
  assign count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wptr_r <= wptr_r + 1'b1;
      if (pop) rptr_r <= rptr_r + 1'b1;
      count_r <= count_nxt;
      in_ready <= count_nxt < (AW + 1)'(DEPTH);
      if (pop) out_valid <= 1'b1;
      else if (out_ready) out_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wptr_r] <= in_data;
    if (pop) out_data <= mem[rptr_r];
  end
endmodule

// >>> bench/vfc_video_source.sv
// upstream video source model: presents queued beats on the stream input
module vfc_video_source (
  input wire logic clk,
  input wire logic slow,
  input wire logic tready,
  output vfc_pkg::vfc_beat_t beat,
  output logic tvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  vfc_pkg::vfc_beat_t q[$];
  logic taken;
  logic gap;

  task push(input vfc_pkg::vfc_beat_t b);
    q.push_back(b);
  endtask

  initial begin
    beat = '0;
    tvalid = 1'b0;
    gap = 1'b0;
    forever begin
      @(posedge clk);
      taken = tvalid && tready;
      #1;
      gap = ~gap;
      if (taken) void'(q.pop_front());
      // a beat stays put until taken; slow mode idles every other cycle
      if (!tvalid || taken) begin
        if (q.size() > 0 && !(slow && gap)) begin
          beat = q[0];
          tvalid = 1'b1;
        end else begin
          // idle lines toggle so stale data is never mistaken for a beat
          beat.data = ~beat.data;
          beat.sof = 1'b0;
          beat.eol = 1'b0;
          tvalid = 1'b0;
        end
      end
    end
  end
endmodule

// >>> bench/vfc_checker_test.sv
// self-checking bench for the frame crc checker with a reference model
module vfc_checker_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, reset_n, vid_reset_n, slow;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, seed, stall, fmt;
  logic [1:0] bresp, rresp;
  vfc_pkg::vfc_beat_t sbeat;
  logic svalid, sready, muser, mlast, mvalid, mready;
  logic [95:0] mdata;
  logic [15:0] acc [3];
  logic [15:0] res [3];
  int errors, comparisons, linepix, par, miss;
  vfc_pkg::vfc_beat_t expq[$];

  vfc_checker i_vfc_checker (.core_clk(core_clk), .reset_n(reset_n), .vid_reset_n(vid_reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axis_video_tdata(sbeat.data), .s_axis_video_tuser(sbeat.sof),
    .s_axis_video_tlast(sbeat.eol), .s_axis_video_tvalid(svalid),
    .s_axis_video_tready(sready), .m_axis_video_tdata(mdata), .m_axis_video_tuser(muser),
    .m_axis_video_tlast(mlast), .m_axis_video_tvalid(mvalid), .m_axis_video_tready(mready));

  vfc_video_source i_vfc_video_source (.clk(core_clk), .slow(slow), .tready(sready),
    .beat(sbeat), .tvalid(svalid));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] crc8(logic [15:0] c, logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
    end
    return c;
  endfunction

  task print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task check(input string name, input logic [97:0] exp, input logic [97:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  // bounded wait for a handshake, counted as a mismatch on expiry
  task automatic wait_high(ref logic s);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge core_clk);
      if (s === 1'b1) break;
    end
    if (n == 300) begin
      check("handshake", 1, 0);
      print_verdict();
    end
  endtask

  task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    awaddr = a;
    wdata = d;
    awvalid = 1'b1;
    wvalid = 1'b1;
    wait_high(awready);
    check("write ready", 1'b1, wready);
    #1 awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b1;
    wait_high(bvalid);
    check("write response", resp, bresp);
    #1 bready = 1'b0;
  endtask

  task axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    araddr = a;
    arvalid = 1'b1;
    wait_high(arready);
    #1 arvalid = 1'b0;
    rready = 1'b1;
    wait_high(rvalid);
    check($sformatf("read data %h", a), d, rdata);
    check("read response", resp, rresp);
    #1 rready = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // stream model
  // ----------------------------------------------------------------
  task send_beat(input logic [95:0] d, input logic sof, input logic eol, input int ppc,
                 input logic ycc);
    logic [23:0] px;
    expq.push_back({d, sof, eol});
    i_vfc_video_source.push({d, sof, eol});
    if (sof) begin
      res = acc;
      acc = '{default: 16'h0000};
      par = 0;
    end
    for (int p = 0; p < ppc; p++) begin
      px = d[24*p+:24];
      if (ycc) begin
        acc[2] = crc8(acc[2], px[7:0]);
        acc[par ? 0 : 1] = crc8(acc[par ? 0 : 1], px[15:8]);
        par = 1 - par;
      end else begin
        acc[0] = crc8(acc[0], px[23:16]);
        acc[1] = crc8(acc[1], px[7:0]);
        acc[2] = crc8(acc[2], px[15:8]);
      end
    end
    linepix += ppc;
    if (eol) begin
      if (linepix < 8 && miss < 15) miss++;
      linepix = 0;
    end
  endtask

  task send_frame(input int ppc, input logic ycc, input int lines, input int shorts);
    int n;
    for (int l = 0; l < lines; l++) begin
      n = (l < shorts) ? 4 : 8;
      for (int p = 0; p < n; p += ppc) begin
        seed = lfsr(seed);
        send_beat({seed, lfsr(seed), ~seed}, l == 0 && p == 0, p + ppc >= n, ppc, ycc);
      end
    end
  endtask

  task drain_and_check();
    int n;
    for (n = 0; n < 600; n++) begin
      @(posedge core_clk);
      if (i_vfc_video_source.q.size() == 0 && expq.size() == 0) break;
    end
    if (n == 600) check("stream drain", 0, 1);
    #1;
    axi_read(vfc_pkg::OFS_CRC_RG, {res[1], res[0]}, vfc_pkg::RESP_OKAY);
    axi_read(vfc_pkg::OFS_CRC_B, {16'h0000, res[2]}, vfc_pkg::RESP_OKAY);
    axi_read(vfc_pkg::OFS_MISSING, {20'h00000, {3{miss[3:0]}}}, vfc_pkg::RESP_OKAY);
  endtask

  always @(posedge core_clk) begin
    if (mvalid === 1'b1 && mready === 1'b1) begin
      if (expq.size() == 0) check("stream beat count", 0, 1);
      else check("stream beat", expq.pop_front(), {mdata, muser, mlast});
    end
    #1;
    stall = lfsr(stall);
    mready = stall[0] | stall[3];
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset_n, vid_reset_n, awvalid, wvalid, bready, arvalid, rready, slow, mready} = '0;
    {awaddr, araddr, wdata} = '0;
    {errors, comparisons, linepix, par, miss} = '0;
    seed = 32'h78f2ce8f;
    stall = 32'h78f2ce8f;
    acc = '{default: 16'h0000};
    res = '{default: 16'h0000};
    repeat (5) @(posedge core_clk);
    #1 reset_n = 1'b1;
    vid_reset_n = 1'b1;
    @(posedge core_clk);
    #1 axi_read(vfc_pkg::OFS_FORMAT, 32'h1, vfc_pkg::RESP_OKAY);
    axi_read(vfc_pkg::OFS_GEOMETRY, 32'h0, vfc_pkg::RESP_OKAY);
    axi_read(8'h14, 32'h0, vfc_pkg::RESP_SLVERR);
    axi_write(8'h14, 32'h5a5a5a5a, vfc_pkg::RESP_SLVERR);
    axi_write(vfc_pkg::OFS_CRC_B, 32'hffffffff, vfc_pkg::RESP_OKAY);
    axi_write(vfc_pkg::OFS_GEOMETRY, 32'h00030008, vfc_pkg::RESP_OKAY);
    axi_read(vfc_pkg::OFS_GEOMETRY, 32'h00030008, vfc_pkg::RESP_OKAY);
    drain_and_check();
    // 1, 2, 4 pixels rgb then single-pixel 4:2:2; each frame captures the last
    for (int s = 0; s < 4; s++) begin
      slow = s[0];
      fmt = (s == 3) ? 32'h80000001 : (32'h1 << s);
      axi_write(vfc_pkg::OFS_FORMAT, fmt, vfc_pkg::RESP_OKAY);
      axi_read(vfc_pkg::OFS_FORMAT, fmt, vfc_pkg::RESP_OKAY);
      send_frame((s == 3) ? 1 : (1 << s), s == 3, 3, 0);
      drain_and_check();
    end
    axi_write(vfc_pkg::OFS_FORMAT, 32'h1, vfc_pkg::RESP_OKAY);
    send_frame(1, 0, 3, 2);
    drain_and_check();
    send_frame(1, 0, 1, 0);
    drain_and_check();
    vid_reset_n = 1'b0;
    @(posedge core_clk);
    #1 vid_reset_n = 1'b1;
    acc = '{default: 16'h0000};
    par = 0;
    send_frame(1, 0, 1, 0);
    drain_and_check();
    send_frame(1, 0, 1, 0);
    drain_and_check();
    axi_write(vfc_pkg::OFS_FORMAT, 32'h11, vfc_pkg::RESP_OKAY);
    res = '{default: 16'h0000};
    miss = 0;
    repeat (3) @(posedge core_clk);
    #1 drain_and_check();
    axi_read(vfc_pkg::OFS_FORMAT, 32'h1, vfc_pkg::RESP_OKAY);
    reset_n = 1'b0;
    @(posedge core_clk);
    #1 reset_n = 1'b1;
    @(posedge core_clk);
    #1 axi_read(vfc_pkg::OFS_GEOMETRY, 32'h0, vfc_pkg::RESP_OKAY);
    print_verdict();
  end
endmodule
